// file: two_wire_master_map.svh
/*
  Register offsets, field positions, reset values and bus timing counts
  of the two-wire master. Assumes a 200 MHz clock and byte addressing.
*/
`ifndef TWO_WIRE_MASTER_MAP_SVH
`define TWO_WIRE_MASTER_MAP_SVH

`define CLK_MHZ              200
`define OFF_TASK_RX          12'h000
`define OFF_TASK_TX          12'h008
`define OFF_TASK_STOP        12'h014
`define OFF_STATUS           12'h600
`define OFF_ERROR_SOURCE     12'h4C4
`define OFF_ENABLE           12'h500
`define OFF_CLOCK_PSEL       12'h508
`define OFF_DATA_PSEL        12'h50C
`define OFF_RECEIVE_BYTE     12'h518
`define OFF_TRANSMIT_BYTE    12'h51C
`define OFF_BIT_RATE         12'h524
`define OFF_SLAVE_ADDRESS    12'h588
`define PSEL_RESET           32'hFFFFFFFF
`define PSEL_CONNECT_BIT     31
`define PSEL_PORT_BIT        5
`define RATE_RESET           32'h04000000
`define RATE_100K_CODE       32'h01980000
`define RATE_250K_CODE       32'h04000000
`define RATE_400K_CODE       32'h06680000
`define ENABLE_ON            4'h5
`define ERR_OVERRUN_BIT      0
`define ERR_ADDR_NACK_BIT    1
`define ERR_DATA_NACK_BIT    2
`define START_LAT_NS         1500
`define START_LAT_CYC        ((`START_LAT_NS * `CLK_MHZ) / 1000)
`define HD_STA_100_NS        10000
`define HD_STA_250_NS        4000
`define HD_STA_400_NS        2500
`define SU_STO_100_NS        5000
`define SU_STO_250_NS        2000
`define SU_STO_400_NS        1250
`define BUF_100_NS           5800
`define BUF_250_NS           2700
`define BUF_400_NS           2100
`define NS2CYC(ns)           (((ns) * `CLK_MHZ + 999) / 1000)
`define HALF_100_NS          5000
`define HALF_250_NS          2000
`define HALF_400_NS          1250

`endif

// file: two_wire_master_pkg.sv
/*
  Types shared by the two-wire master files.
  Assumes the map header is compiled alongside.
*/
package two_wire_master_pkg;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0000,
    ST_LAT   = 4'b0001,
    ST_START = 4'b0010,
    ST_LOW   = 4'b0011,
    ST_HIGH  = 4'b0100,
    ST_ACK_L = 4'b0101,
    ST_ACK_H = 4'b0110,
    ST_STO_L = 4'b0111,
    ST_STO_H = 4'b1000,
    ST_BUF   = 4'b1001
  } bus_state_t;
endpackage

// file: byte_skid_buffer.sv
/*
  Two-entry buffer with valid/ready on both sides.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module byte_skid_buffer #(
  parameter int WIDTH = 8
) (
  input  wire logic             clock,     // system clock
  input  wire logic             resetn,    // async reset, active low
  input  wire logic             inValid,   // writer has a word
  output logic                  inReady,   // space free
  input  wire logic [WIDTH-1:0] inData,    // word in
  output logic                  outValid,  // word available
  input  wire logic             outReady,  // reader takes it
  output logic      [WIDTH-1:0] outData    // oldest word
);
  logic [WIDTH-1:0] mem_q [2];
  logic [WIDTH-1:0] mem_d [2];
  logic             rdPtr_q, rdPtr_d, wrPtr_q, wrPtr_d;
  logic [1:0]       count_q, count_d;
  logic             push, pop;

  always_comb begin
    push     = inValid && (count_q != 2'h2);
    pop      = outValid && outReady;
    mem_d    = mem_q;
    wrPtr_d  = wrPtr_q;
    rdPtr_d  = rdPtr_q;
    if (push) begin
      mem_d[wrPtr_q] = inData;
      wrPtr_d        = ~wrPtr_q;
    end
    if (pop) begin
      rdPtr_d = ~rdPtr_q;
    end
    count_d = count_q + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      rdPtr_q  <= 1'b0;
      wrPtr_q  <= 1'b0;
      count_q  <= 2'h0;
    end else begin
      mem_q    <= mem_d;
      rdPtr_q  <= rdPtr_d;
      wrPtr_q  <= wrPtr_d;
      count_q  <= count_d;
    end
  end

  assign inReady  = (count_q != 2'h2);
  assign outValid = (count_q != 2'h0);
  assign outData  = mem_q[rdPtr_q];
endmodule // byte_skid_buffer

// file: two_wire_master.sv
/*
  Two-wire master: registers over Avalon-MM and bus START/STOP timing.
  Assumes external pull-ups and slaves that do not stretch the clock.
*/
// Chosen here: the Avalon-MM register port.
// How it works
// [RULE_01] bit 31 of each pin-select register set means disconnected.
// [RULE_02] pin-select holds pin 0..31 in bits 4:0 and port in bit 5.
// [RULE_03] bit-rate codes pick 100, 250 or 400 kbps timing.
// [RULE_04] slave address register at 0x588, low seven bits on the bus.
// [RULE_05] bus activity begins about 1.5 us after a start task.
// [RULE_06] START is held at least the hold time for the chosen rate.
// [RULE_07] clock stays high at least the setup time before STOP.
// [RULE_08] bus stays free at least the buffer time after STOP.
// [RULE_09] enable value 5 turns on, anything else leaves it off.
// [RULE_10] overrun, address NACK and data NACK flags clear by write one.
`timescale 1ns/1ps
`include "two_wire_master_map.svh"
module two_wire_master (
  input  wire logic        clock,            // 200 MHz system clock
  input  wire logic        resetn,           // async reset, active low
  input  wire logic [11:0] address,          // byte address
  input  wire logic        read,             // read request
  input  wire logic        write,            // write request
  input  wire logic [31:0] writedata,        // write data
  input  wire logic [3:0]  byteenable,       // byte lanes
  output logic      [31:0] readdata,         // read data
  output logic             waitrequest,      // high until answered
  input  wire logic        sclIn,            // clock line level
  output logic             sclOutEn_n,       // low pulls clock line low
  input  wire logic        sdaIn,            // data line level
  output logic             sdaOutEn_n,       // low pulls data line low
  output logic      [6:0]  clockPin,         // port and pin of clock
  output logic      [6:0]  dataPin           // port and pin of data
);
  // pins carry {disconnected, port, pin[4:0]}
  typedef two_wire_master_pkg::bus_state_t st_t;
  localparam st_t ST_IDLE  = two_wire_master_pkg::ST_IDLE;
  localparam st_t ST_LAT   = two_wire_master_pkg::ST_LAT;
  localparam st_t ST_START = two_wire_master_pkg::ST_START;
  localparam st_t ST_LOW   = two_wire_master_pkg::ST_LOW;
  localparam st_t ST_HIGH  = two_wire_master_pkg::ST_HIGH;
  localparam st_t ST_ACK_L = two_wire_master_pkg::ST_ACK_L;
  localparam st_t ST_ACK_H = two_wire_master_pkg::ST_ACK_H;
  localparam st_t ST_STO_L = two_wire_master_pkg::ST_STO_L;
  localparam st_t ST_STO_H = two_wire_master_pkg::ST_STO_H;
  localparam st_t ST_BUF   = two_wire_master_pkg::ST_BUF;

  st_t         st_q, st_d;
  logic [15:0] cnt_q, cnt_d;
  logic [3:0]  bitN_q, bitN_d;
  logic [7:0]  sh_q, sh_d;
  logic        isRx_q, isRx_d, addrPh_q, addrPh_d, stopReq_q, stopReq_d;
  logic        scl_q, scl_d, sda_q, sda_d;
  logic [2:0]  err_q, err_d;
  logic [3:0]  en_q, en_d;
  logic [31:0] cps_q, cps_d, dps_q, dps_d, rate_q, rate_d;
  logic [7:0]  txb_q, txb_d;
  logic [6:0]  sadr_q, sadr_d;
  logic [31:0] rd_q, rd_d;
  logic        ack_q, ack_d;
  logic        wait_q, wait_d;
  logic [6:0]  cpin_q, cpin_d, dpin_q, dpin_d;
  logic        enabled, wr, rdAcc, bufInReady, bufOutValid, popRx, pushRx;
  logic [7:0]  bufOut;

  function automatic logic [15:0] ns_cyc(input int ns);
    ns_cyc = 16'(`NS2CYC(ns));
  endfunction

  // rate-dependent timing; unknown codes fall back to 250 kbps
  function automatic logic [15:0] pick(input logic [31:0] r,
                                       input int a, input int b,
                                       input int c);
    if (r == `RATE_100K_CODE) pick = ns_cyc(a);
    else if (r == `RATE_400K_CODE) pick = ns_cyc(c);
    else pick = ns_cyc(b);
  endfunction

  logic [15:0] tHalf, tHdSta, tSuSto, tBuf;

  always_comb begin
    // reload value: a phase lasts the count plus one cycle
    tHalf  = pick(rate_q, `HALF_100_NS, `HALF_250_NS,
                  `HALF_400_NS) - 16'h1;                             // [RULE_03]
    tHdSta = pick(rate_q, `HD_STA_100_NS, `HD_STA_250_NS,
                  `HD_STA_400_NS);                                   // [RULE_06]
    tSuSto = pick(rate_q, `SU_STO_100_NS, `SU_STO_250_NS,
                  `SU_STO_400_NS);                                   // [RULE_07]
    tBuf   = pick(rate_q, `BUF_100_NS, `BUF_250_NS, `BUF_400_NS);    // [RULE_08]
  end

  assign enabled = (en_q == `ENABLE_ON);                             // [RULE_09]
  // writes land on the edge that samples waitrequest low
  assign wr      = write && ack_q;
  assign rdAcc   = read && !ack_q;
  assign popRx   = rdAcc && address == `OFF_RECEIVE_BYTE;

  // register side
  always_comb begin
    en_d   = en_q;
    cps_d  = cps_q;
    dps_d  = dps_q;
    rate_d = rate_q;
    txb_d  = txb_q;
    sadr_d = sadr_q;
    rd_d   = rd_q;
    ack_d  = (read || write) && !ack_q;
    if (wr && byteenable[0]) begin
      unique case (address)
        `OFF_ENABLE:        en_d   = writedata[3:0];
        `OFF_TRANSMIT_BYTE: txb_d  = writedata[7:0];
        `OFF_SLAVE_ADDRESS: sadr_d = writedata[6:0];                 // [RULE_04]
        default: ;
      endcase
    end
    if (wr && address == `OFF_CLOCK_PSEL) cps_d = writedata;         // [RULE_01]
    if (wr && address == `OFF_DATA_PSEL)  dps_d = writedata;
    if (wr && address == `OFF_BIT_RATE)   rate_d = writedata;
    if (rdAcc) begin
      unique case (address)
        `OFF_ERROR_SOURCE:  rd_d = {29'h0, err_q};
        `OFF_ENABLE:        rd_d = {28'h0, en_q};
        `OFF_CLOCK_PSEL:    rd_d = cps_q;
        `OFF_DATA_PSEL:     rd_d = dps_q;
        `OFF_RECEIVE_BYTE:  rd_d = {24'h0, bufOutValid ? bufOut : 8'h00};
        `OFF_TRANSMIT_BYTE: rd_d = {24'h0, txb_q};
        `OFF_BIT_RATE:      rd_d = rate_q;
        `OFF_SLAVE_ADDRESS: rd_d = {25'h0, sadr_q};
        `OFF_STATUS:        rd_d = {27'h0, bufOutValid, st_q};
        default:            rd_d = 32'h00000000;
      endcase
    end
    wait_d = !ack_d;
    // disabled block leaves both signals on no pin
    cpin_d = {cps_q[`PSEL_CONNECT_BIT] | ~enabled,
              cps_q[`PSEL_PORT_BIT], cps_q[4:0]}; // [RULE_01] [RULE_02]
    dpin_d = {dps_q[`PSEL_CONNECT_BIT] | ~enabled,
              dps_q[`PSEL_PORT_BIT], dps_q[4:0]}; // [RULE_01] [RULE_02]
  end

  // bus side
  always_comb begin
    st_d      = st_q;
    cnt_d     = cnt_q;
    bitN_d    = bitN_q;
    sh_d      = sh_q;
    isRx_d    = isRx_q;
    addrPh_d  = addrPh_q;
    stopReq_d = stopReq_q;
    scl_d     = scl_q;
    sda_d     = sda_q;
    err_d     = err_q;
    pushRx    = 1'b0;
    if (wr && address == `OFF_ERROR_SOURCE)
      err_d = err_q & ~writedata[2:0];                               // [RULE_10]
    if (wr && address == `OFF_TASK_STOP) stopReq_d = 1'b1;
    if (cnt_q != 16'h0) cnt_d = cnt_q - 16'h1;
    unique case (st_q)
      ST_IDLE: begin
        scl_d = 1'b1;
        sda_d = 1'b1;
        stopReq_d = 1'b0;
        if (enabled && wr && (address == `OFF_TASK_RX ||
                              address == `OFF_TASK_TX)) begin
          isRx_d = (address == `OFF_TASK_RX);
          cnt_d  = 16'(`START_LAT_CYC);                              // [RULE_05]
          st_d   = ST_LAT;
        end
      end
      ST_LAT: if (cnt_q == 16'h0) begin
        sda_d = 1'b0;
        cnt_d = tHdSta;                                              // [RULE_06]
        st_d  = ST_START;
      end
      ST_START: if (cnt_q == 16'h0) begin
        scl_d    = 1'b0;
        sh_d     = {sadr_q, isRx_q};
        addrPh_d = 1'b1;
        bitN_d   = 4'h0;
        cnt_d    = tHalf;
        st_d     = ST_LOW;
      end
      ST_LOW: begin
        if (cnt_q == tHalf - 16'h1)
          sda_d = (isRx_q && !addrPh_q) ? 1'b1 : sh_q[7];
        if (cnt_q == 16'h0) begin
          scl_d = 1'b1;
          cnt_d = tHalf;
          st_d  = ST_HIGH;
        end
      end
      ST_HIGH: if (cnt_q == 16'h0) begin
        scl_d  = 1'b0;
        sh_d   = {sh_q[6:0], sdaIn};
        bitN_d = bitN_q + 4'h1;
        cnt_d  = tHalf;
        st_d   = (bitN_q == 4'h7) ? ST_ACK_L : ST_LOW;
      end
      ST_ACK_L: begin
        if (cnt_q == tHalf - 16'h1)
          sda_d = (isRx_q && !addrPh_q) ? stopReq_q : 1'b1;
        if (cnt_q == 16'h0) begin
          scl_d = 1'b1;
          cnt_d = tHalf;
          st_d  = ST_ACK_H;
        end
      end
      ST_ACK_H: if (cnt_q == 16'h0) begin
        scl_d  = 1'b0;
        bitN_d = 4'h0;
        cnt_d  = tHalf;
        st_d   = ST_LOW;
        if (isRx_q && !addrPh_q) begin
          pushRx = 1'b1;
          if (!bufInReady) err_d[`ERR_OVERRUN_BIT] = 1'b1;           // [RULE_10]
        end
        if (!isRx_q || addrPh_q) begin
          if (sdaIn) begin
            if (addrPh_q) err_d[`ERR_ADDR_NACK_BIT] = 1'b1;          // [RULE_10]
            else err_d[`ERR_DATA_NACK_BIT] = 1'b1;
            st_d = ST_STO_L;
          end
          sh_d = txb_q;
        end
        addrPh_d = 1'b0;
        if (stopReq_q) st_d = ST_STO_L;
      end
      ST_STO_L: begin
        if (cnt_q == tHalf - 16'h1) sda_d = 1'b0;
        if (cnt_q == 16'h0) begin
          scl_d = 1'b1;
          cnt_d = tSuSto;                                            // [RULE_07]
          st_d  = ST_STO_H;
        end
      end
      ST_STO_H: if (cnt_q == 16'h0) begin
        sda_d = 1'b1;
        cnt_d = tBuf;                                                // [RULE_08]
        st_d  = ST_BUF;
      end
      ST_BUF: if (cnt_q == 16'h0) st_d = ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
    if (!enabled) st_d = ST_IDLE;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_q      <= two_wire_master_pkg::ST_IDLE;
      cnt_q     <= 16'h0000;
      bitN_q    <= 4'h0;
      sh_q      <= 8'h00;
      isRx_q    <= 1'b0;
      addrPh_q  <= 1'b0;
      stopReq_q <= 1'b0;
      scl_q     <= 1'b1;
      sda_q     <= 1'b1;
      err_q     <= 3'h0;
      en_q      <= 4'h0;
      cps_q     <= `PSEL_RESET;
      dps_q     <= `PSEL_RESET;
      rate_q    <= `RATE_RESET;
      txb_q     <= 8'h00;
      sadr_q    <= 7'h00;
      rd_q      <= 32'h00000000;
      ack_q     <= 1'b0;
      wait_q    <= 1'b1;
      cpin_q    <= 7'h7F;
      dpin_q    <= 7'h7F;
    end else begin
      st_q      <= st_d;
      cnt_q     <= cnt_d;
      bitN_q    <= bitN_d;
      sh_q      <= sh_d;
      isRx_q    <= isRx_d;
      addrPh_q  <= addrPh_d;
      stopReq_q <= stopReq_d;
      scl_q     <= scl_d;
      sda_q     <= sda_d;
      err_q     <= err_d;
      en_q      <= en_d;
      cps_q     <= cps_d;
      dps_q     <= dps_d;
      rate_q    <= rate_d;
      txb_q     <= txb_d;
      sadr_q    <= sadr_d;
      rd_q      <= rd_d;
      ack_q     <= ack_d;
      wait_q    <= wait_d;
      cpin_q    <= cpin_d;
      dpin_q    <= dpin_d;
    end
  end

  // received bytes; a full buffer drops the byte and flags overrun
  byte_skid_buffer #(.WIDTH(8)) rxBuf (
    .clock    (clock),
    .resetn   (resetn),
    .inValid  (pushRx),
    .inReady  (bufInReady),
    .inData   (sh_q),
    .outValid (bufOutValid),
    .outReady (popRx),
    .outData  (bufOut)
  );

  assign readdata    = rd_q;
  assign waitrequest = wait_q;
  assign sclOutEn_n  = scl_q;
  assign sdaOutEn_n  = sda_q;
  assign clockPin    = cpin_q;                               // [RULE_01]
  assign dataPin     = dpin_q;                               // [RULE_02]
endmodule // two_wire_master

// file: two_wire_master_asserts.sv
/*
  Port-level checker for two_wire_master, bound at the foot of this file.
  Assumes the map header and a 200 MHz clock; bounds use 400 kbps minima.
*/
`timescale 1ns/1ps
`include "two_wire_master_map.svh"
module two_wire_master_asserts (
  input wire logic        clock,        // system clock
  input wire logic        resetn,       // async reset, active low
  input wire logic [11:0] address,      // byte address
  input wire logic        read,         // read request
  input wire logic        write,        // write request
  input wire logic [31:0] writedata,    // write data
  input wire logic        waitrequest,  // bus answer
  input wire logic        sclOutEn_n,   // clock line pull
  input wire logic        sdaOutEn_n,   // data line pull
  input wire logic [6:0]  clockPin,     // clock pin select
  input wire logic [6:0]  dataPin       // data pin select
);
  int   sclHi;
  int   sdaLo;
  int   idle;
  logic enQ;
  logic startQ;
  logic acc;
  assign acc = write && !waitrequest;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // idle starts large: the first start after reset owes no free time
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sclHi  <= 0;
      sdaLo  <= 0;
      idle   <= 9999;
      enQ    <= 1'b0;
      startQ <= 1'b0;
    end else begin
      sclHi  <= sclOutEn_n ? sclHi + 1 : 0;
      sdaLo  <= sdaOutEn_n ? 0 : sdaLo + 1;
      idle   <= (sclOutEn_n && sdaOutEn_n) ? idle + 1 : 0;
      startQ <= sclOutEn_n && (startQ || $fell(sdaOutEn_n));
      if (acc && address == `OFF_ENABLE)
        enQ <= writedata[3:0] == `ENABLE_ON;
    end
  end
  property p_answer; $rose(read || write) |=> !waitrequest; endproperty
  a_answer: assert property (p_answer)
    else $error("request not answered in one cycle");
  property p_stands; !waitrequest |=> waitrequest; endproperty
  a_stands: assert property (p_stands)
    else $error("answer held longer than one cycle");
  property p_pin_off;
    acc && address == `OFF_CLOCK_PSEL && writedata[31] |=> ##1 clockPin[6];
  endproperty
  a_pin_off: assert property (p_pin_off)
    else $error("clock pin still connected");
  property p_latency;
    acc && enQ && idle > 1200 &&
      (address == `OFF_TASK_TX || address == `OFF_TASK_RX)
      |-> ##[280:320] $fell(sdaOutEn_n);
  endproperty
  a_latency: assert property (p_latency)
    else $error("start not issued near the latency");
  property p_start_hold; $fell(sclOutEn_n) && startQ |-> sdaLo >= 500;
  endproperty
  a_start_hold: assert property (p_start_hold)
    else $error("start hold too short");
  property p_stop_setup; $rose(sdaOutEn_n) && sclOutEn_n |-> sclHi >= 250;
  endproperty
  a_stop_setup: assert property (p_stop_setup)
    else $error("stop setup too short");
  property p_free; $fell(sdaOutEn_n) && sclOutEn_n |-> idle >= 420;
  endproperty
  a_free: assert property (p_free)
    else $error("bus free time too short");
  property p_off_pins;
    !enQ && !$past(enQ) |-> clockPin[6] && dataPin[6];
  endproperty
  a_off_pins: assert property (p_off_pins)
    else $error("pins connected while disabled");
  c_task: cover property (acc && address == `OFF_TASK_TX);
  c_stop: cover property ($rose(sdaOutEn_n) && sclOutEn_n);
  c_err: cover property (acc && address == `OFF_ERROR_SOURCE);
endmodule  // two_wire_master_asserts

bind two_wire_master two_wire_master_asserts i_chk (.clock(clock),
  .resetn(resetn), .address(address), .read(read), .write(write),
  .writedata(writedata), .waitrequest(waitrequest),
  .sclOutEn_n(sclOutEn_n), .sdaOutEn_n(sdaOutEn_n),
  .clockPin(clockPin), .dataPin(dataPin));

// file: two_wire_slave_model.sv
/*
  Behavioural two-wire slave: acks its own address, takes written bytes,
  returns a fixed byte on reads. Assumes pull-ups and no clock stretching.
*/
`timescale 1ns/1ps
module two_wire_slave_model #(
  parameter logic [6:0] OWN_ADDR = 7'h2A  // address answered
) (
  input  wire logic       scl,       // clock line level
  input  wire logic       sda,       // data line level
  output logic            sdaEn_n,   // low pulls data line
  input  wire logic [7:0] txByte,    // byte sent on reads
  input  wire logic       nackData,  // refuse written bytes
  output logic      [7:0] gotAddr,   // last address byte
  output logic      [7:0] gotData    // last written byte
);
  logic [7:0] sh;
  logic       act;
  logic       rd;
  int         cnt;
  int         p;
  int         b;
  initial begin
    sdaEn_n = 1'b1;
    act = 1'b0;
    rd = 1'b0;
    gotAddr = 8'h00;
    gotData = 8'h00;
  end
  always @(negedge sda) if (scl) begin
    act = 1'b1;
    cnt = 0;
    p = 8;
  end
  always @(posedge sda) if (scl) begin
    act = 1'b0;
    sdaEn_n = 1'b1;
  end
  always @(posedge scl) if (act) begin
    if (p < 8)
      sh = {sh[6:0], sda};
    else if (rd && b > 0 && sda)
      act = 1'b0;  // master refused: stop driving
  end
  always @(negedge scl) begin
    sdaEn_n = 1'b1;
    if (act) begin
      cnt++;
      p = (cnt - 1) % 9;
      b = (cnt - 1) / 9;
      if (p == 8 && b == 0) begin
        gotAddr = sh;
        rd = sh[0];
        sdaEn_n = sh[7:1] != OWN_ADDR;
      end else if (p == 8 && !rd) begin
        gotData = sh;
        sdaEn_n = nackData;
      end else if (p < 8 && rd && b > 0)
        sdaEn_n = txByte[7 - p];
    end
  end
endmodule  // two_wire_slave_model

// file: two_wire_master_tb.sv
/*
  Self-checking bench for two_wire_master with the slave model on the
  lines. Assumes pull-ups on both lines and a 200 MHz clock.
*/
`timescale 1ns/1ps
`include "two_wire_master_map.svh"
module two_wire_master_tb;
  logic        clock = 0;
  logic        resetn = 0;
  logic        read = 0;
  logic        write = 0;
  logic [11:0] address = '0;
  logic [31:0] writedata = '0;
  logic [31:0] readdata;
  logic [31:0] rd;
  logic        waitrequest;
  logic        sclOutEn_n;
  logic        sdaOutEn_n;
  logic        slvSda_n;
  logic        sclW;
  logic        sdaW;
  logic [6:0]  clockPin;
  logic [6:0]  dataPin;
  logic [7:0]  gotAddr;
  logic [7:0]  gotData;
  logic        nackData = 0;
  int          failures = 0;
  int          samplesChecked = 0;
  assign sclW = sclOutEn_n;
  assign sdaW = sdaOutEn_n & slvSda_n;
  always #2.5 clock = ~clock;
  two_wire_master i_dut (.clock(clock), .resetn(resetn), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(4'hF),
    .readdata(readdata), .waitrequest(waitrequest), .sclIn(sclW),
    .sclOutEn_n(sclOutEn_n), .sdaIn(sdaW), .sdaOutEn_n(sdaOutEn_n),
    .clockPin(clockPin), .dataPin(dataPin));
  two_wire_slave_model #(.OWN_ADDR(7'h2A)) i_slave (.scl(sclW),
    .sda(sdaW), .sdaEn_n(slvSda_n), .txByte(8'h3C), .nackData(nackData),
    .gotAddr(gotAddr), .gotData(gotData));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= d;
    // only the watchdog ends a wait that never gets its answer
    do @(posedge clock);
    while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  // status polling also keeps the next start clear of the free time
  task automatic waitIdle;
    do bus(1'b0, `OFF_STATUS, 32'h0);
    while (rd[3:0] !== two_wire_master_pkg::ST_IDLE);
  endtask
  task automatic t_regs;
    logic [11:0] offs [8] = '{`OFF_ERROR_SOURCE, `OFF_ENABLE,
      `OFF_CLOCK_PSEL, `OFF_DATA_PSEL, `OFF_RECEIVE_BYTE,
      `OFF_TRANSMIT_BYTE, `OFF_BIT_RATE, `OFF_SLAVE_ADDRESS};
    logic [31:0] rsts [8] = '{32'h0, 32'h0, `PSEL_RESET, `PSEL_RESET,
      32'h0, 32'h0, `RATE_RESET, 32'h0};
    logic [31:0] codes [3] = '{`RATE_100K_CODE, `RATE_250K_CODE,
      `RATE_400K_CODE};
    foreach (offs[i]) rdc(offs[i], rsts[i]);
    rdc(12'h7FC, 32'h0);
    wr(`OFF_CLOCK_PSEL, 32'h25);
    wr(`OFF_ENABLE, 32'h3);
    repeat (2) @(negedge clock);
    check(32'(clockPin[6]), 32'h1);
    wr(`OFF_ENABLE, 32'h5);
    repeat (2) @(negedge clock);
    check(32'(clockPin), 32'h25);
    wr(`OFF_CLOCK_PSEL, 32'h80000025);
    repeat (2) @(negedge clock);
    check(32'(clockPin), 32'h65);
    wr(`OFF_DATA_PSEL, 32'h80000003);
    repeat (2) @(negedge clock);
    check(32'(dataPin[6]), 32'h1);
    wr(`OFF_DATA_PSEL, 32'h1F);
    repeat (2) @(negedge clock);
    check(32'(dataPin), 32'h1F);
    foreach (codes[i]) begin
      wr(`OFF_BIT_RATE, codes[i]);
      rdc(`OFF_BIT_RATE, codes[i]);
    end
    wr(`OFF_SLAVE_ADDRESS, 32'h2A);
    rdc(`OFF_SLAVE_ADDRESS, 32'h2A);
    wr(`OFF_RECEIVE_BYTE, 32'hFF);
    rdc(`OFF_RECEIVE_BYTE, 32'h0);
  endtask
  task automatic t_xfer(input logic [31:0] code, input int half,
    input logic [6:0] sa, input logic nk, input int falls,
    input logic [31:0] err);
    int n;
    nackData <= nk;
    wr(`OFF_BIT_RATE, code);
    wr(`OFF_SLAVE_ADDRESS, {25'h0, sa});
    wr(`OFF_TRANSMIT_BYTE, 32'hC3);
    wr(`OFF_TASK_TX, 32'h1);
    @(posedge sclW);
    n = 0;
    @(negedge clock);
    while (sclW === 1'b1) begin
      n++;
      @(negedge clock);
    end
    check(32'(n), 32'(half));
    repeat (falls) @(negedge sclW);
    wr(`OFF_TASK_STOP, 32'h1);
    waitIdle;
    check({24'h0, gotAddr}, {24'h0, sa, 1'b0});
    if (err != 32'h2) check({24'h0, gotData}, 32'hC3);
    rdc(`OFF_ERROR_SOURCE, err);
    wr(`OFF_ERROR_SOURCE, err);
    rdc(`OFF_ERROR_SOURCE, 32'h0);
    nackData <= 1'b0;
  endtask
  // three bytes arrive unread, so the last finds the buffer full
  task automatic t_rx_overrun;
    wr(`OFF_BIT_RATE, `RATE_400K_CODE);
    wr(`OFF_SLAVE_ADDRESS, 32'h2A);
    wr(`OFF_TASK_RX, 32'h1);
    repeat (29) @(negedge sclW);
    wr(`OFF_TASK_STOP, 32'h1);
    waitIdle;
    check({24'h0, gotAddr}, 32'h55);
    rdc(`OFF_RECEIVE_BYTE, 32'h3C);
    rdc(`OFF_RECEIVE_BYTE, 32'h3C);
    rdc(`OFF_ERROR_SOURCE, 32'h1);
    wr(`OFF_ERROR_SOURCE, 32'h1);
    rdc(`OFF_ERROR_SOURCE, 32'h0);
  endtask
  task automatic printVerdict;
    $display("checks %0d failures %0d", samplesChecked, failures);
    if (failures == 0 && samplesChecked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (95000) @(posedge clock);
    failures++;
    printVerdict;
  end
  initial begin
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    t_regs;
    t_xfer(`RATE_250K_CODE, 400, 7'h2A, 1'b0, 9, 32'h0);
    t_xfer(`RATE_400K_CODE, 250, 7'h2A, 1'b0, 9, 32'h0);
    t_xfer(`RATE_100K_CODE, 1000, 7'h11, 1'b0, 0, 32'h2);
    t_xfer(`RATE_400K_CODE, 250, 7'h2A, 1'b1, 9, 32'h4);
    t_rx_overrun;
    printVerdict;
  end
endmodule  // two_wire_master_tb
